//--- memmap_consts.svh
// Purpose: Address map constants for the internal memory decoder
// Assumes: Byte-free word addressing; 16-, 32- and 64-bit have own windows, 48-bit shares the 32-bit one via ext48
// Notes:   Offsets are relative to the start of a block's window
`ifndef MEMMAP_CONSTS_SVH
`define MEMMAP_CONSTS_SVH

`define MM_PERIPH_TOP       32'h0003FFFF
`define MM_NORM_BASE        32'h00080000
`define MM_SHORT_BASE       32'h00100000
`define MM_SHORT_END        32'h001FFFFF

`define MM_LONG_ROM_END     18'h07FFF
`define MM_LONG_SRAM0       18'h0C000
`define MM_LONG_SMALL_END   18'h01FFF

`define MM_NORM_ROM_END     18'h0FFFF
`define MM_NORM_SRAM0       18'h18000
`define MM_NORM_SMALL_END   18'h03FFF

`define MM_EXT_ROM_END      18'h0AAA9
`define MM_EXT_SRAM0        18'h10000
`define MM_EXT_SRAM_END     18'h15554
`define MM_EXT_SMALL_END    18'h02AA9

`define MM_SHORT_ROM_END    18'h1FFFF
`define MM_SHORT_SRAM0      18'h30000
`define MM_SHORT_SMALL_END  18'h07FFF

`define MM_BLK0_HW_BASE     18'h00000
`define MM_BLK1_HW_BASE     18'h10000
`define MM_BLK2_HW_BASE     18'h20000
`define MM_BLK3_HW_BASE     18'h28000
`define MM_SRAM_HALFWORDS   196608

`endif

//--- memmap_pkg.sv
// Purpose: Types shared by the internal memory decoder
// Assumes: memmap_consts.svh holds all numeric constants
// Notes:   Port index 0 is the data bus, 1 the program bus, 2 the I/O processor
package memmap_pkg;

  typedef enum logic [1:0] {
    W16 = 2'b00,
    W32 = 2'b01,
    W48 = 2'b10,
    W64 = 2'b11
  } width_t;

  typedef enum logic [1:0] {
    K_NONE   = 2'b00,
    K_PERIPH = 2'b01,
    K_ROM    = 2'b10,
    K_SRAM   = 2'b11
  } kind_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic        ext48;
    logic [31:0] addr;
    logic [63:0] wdata;
  } req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic        periph;
    logic [63:0] rdata;
  } rsp_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [17:0] addr;
    logic [31:0] wdata;
  } periph_t;

  typedef struct packed {
    kind_t       kind;
    width_t      width;
    logic [1:0]  blk;
    logic [17:0] hw;
  } dec_t;

  typedef struct packed {
    rsp_t    [2:0] rsp;
    periph_t [2:0] per;
  } state_t;

endpackage : memmap_pkg

//--- memmap_core.sv
// Purpose: Three-port internal memory with width-aliased address decoding
// Assumes: Requesters run on clk; a request is a one-cycle valid strobe
// Notes:   Storage is kept as 16-bit halfwords so every width aliases onto it
//
// Behaviour
// - Lowest 256K locations go to peripheral registers.
// - Core and I/O accesses finish independently, one cycle.
// - Two core and one I/O transfer per cycle.
// - SRAM holds 96K/192K/64K words by width.
// - Blocks accept 16/32/48/64-bit widths by range.
// - Short-word gap between blocks 2, 3 is reserved.
// - Data and program buses complete independently, one cycle.
`timescale 1ns/100ps
`include "memmap_consts.svh"

module memmap_core #(
  parameter logic [15:0] ROM_FILL = 16'h0000
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Data memory bus
  input  wire memmap_pkg::req_t    data_memory_bus_req,
  output      memmap_pkg::rsp_t    data_memory_bus_rsp,
  output      memmap_pkg::periph_t data_memory_bus_per,
  // Program memory bus
  input  wire memmap_pkg::req_t    program_memory_bus_req,
  output      memmap_pkg::rsp_t    program_memory_bus_rsp,
  output      memmap_pkg::periph_t program_memory_bus_per,
  // I/O processor port
  input  wire memmap_pkg::req_t    io_processor_req,
  output      memmap_pkg::rsp_t    io_processor_rsp,
  output      memmap_pkg::periph_t io_processor_per
);

  localparam int NHW = `MM_SRAM_HALFWORDS;

  logic [15:0]          sram [0:NHW-1];
  memmap_pkg::req_t     [2:0] reqs;
  memmap_pkg::dec_t     [2:0] dec;
  logic [2:0][3:0][17:0] idx;
  logic [2:0][2:0]      nhw;
  logic [2:0][63:0]     rd;
  memmap_pkg::state_t   st_r;
  memmap_pkg::state_t   st_nxt;

  assign reqs = {io_processor_req, program_memory_bus_req, data_memory_bus_req};

  function automatic memmap_pkg::dec_t decode(input logic [31:0] a, input logic ext);
    memmap_pkg::dec_t d;
    logic [17:0]      o;
    logic             big;
    d = '0;
    o = '0;
    big = 1'b0;
    d.kind = memmap_pkg::K_NONE;
    if (a <= `MM_PERIPH_TOP) begin
      d.kind = memmap_pkg::K_PERIPH;
    end else if (a < `MM_NORM_BASE) begin
      d.width = memmap_pkg::W64;
      d.blk = a[17:16];
      big = ~a[17];
      o = {2'b00, a[15:0]};
      if (big && o <= `MM_LONG_ROM_END) begin
        d.kind = memmap_pkg::K_ROM;
        d.hw = 18'(o << 2);
      end else if (big && o >= `MM_LONG_SRAM0) begin
        d.kind = memmap_pkg::K_SRAM;
        d.hw = 18'((o - `MM_LONG_SRAM0) << 2);
      end else if (!big && o <= `MM_LONG_SMALL_END) begin
        d.kind = memmap_pkg::K_SRAM;
        d.hw = 18'(o << 2);
      end
    end else if (a < `MM_SHORT_BASE && ext) begin
      d.width = memmap_pkg::W48;
      d.blk = a[18:17];
      big = ~a[18];
      o = {1'b0, a[16:0]};
      if (big && o <= `MM_EXT_ROM_END) begin
        d.kind = memmap_pkg::K_ROM;
        d.hw = 18'(o * 3);
      end else if (big && o >= `MM_EXT_SRAM0 && o <= `MM_EXT_SRAM_END) begin
        d.kind = memmap_pkg::K_SRAM;
        d.hw = 18'((o - `MM_EXT_SRAM0) * 3);
      end else if (!big && o <= `MM_EXT_SMALL_END) begin
        d.kind = memmap_pkg::K_SRAM;
        d.hw = 18'(o * 3);
      end
    end else if (a < `MM_SHORT_BASE) begin
      d.width = memmap_pkg::W32;
      d.blk = a[18:17];
      big = ~a[18];
      o = {1'b0, a[16:0]};
      if (big && o <= `MM_NORM_ROM_END) begin
        d.kind = memmap_pkg::K_ROM;
        d.hw = 18'(o << 1);
      end else if (big && o >= `MM_NORM_SRAM0) begin
        d.kind = memmap_pkg::K_SRAM;
        d.hw = 18'((o - `MM_NORM_SRAM0) << 1);
      end else if (!big && o <= `MM_NORM_SMALL_END) begin
        d.kind = memmap_pkg::K_SRAM;
        d.hw = 18'(o << 1);
      end
    end else if (a <= `MM_SHORT_END) begin
      d.width = memmap_pkg::W16;
      d.blk = a[19:18];
      big = ~a[19];
      o = a[17:0];
      if (big && o <= `MM_SHORT_ROM_END) begin
        d.kind = memmap_pkg::K_ROM;
        d.hw = o;
      end else if (big && o >= `MM_SHORT_SRAM0) begin
        d.kind = memmap_pkg::K_SRAM;
        d.hw = o - `MM_SHORT_SRAM0;
      end else if (!big && o <= `MM_SHORT_SMALL_END) begin
        d.kind = memmap_pkg::K_SRAM; // Gap above this stays K_NONE
        d.hw = o;
      end
    end
    return d;
  endfunction : decode

  function automatic logic [17:0] blk_base(input logic [1:0] b);
    logic [17:0] r;
    r = `MM_BLK0_HW_BASE;
    case (b)
      2'h0:    r = `MM_BLK0_HW_BASE;
      2'h1:    r = `MM_BLK1_HW_BASE;
      2'h2:    r = `MM_BLK2_HW_BASE;
      2'h3:    r = `MM_BLK3_HW_BASE;
      default: r = `MM_BLK0_HW_BASE;
    endcase
    return r;
  endfunction : blk_base

  // Each port decodes and reads on its own path, so no port waits on another
  genvar gp, gh;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_port
      assign dec[gp] = decode(reqs[gp].addr, reqs[gp].ext48);
      assign nhw[gp] = 3'({1'b0, dec[gp].width}) + 3'h1;
      for (gh = 0; gh < 4; gh++) begin : g_hw
        assign idx[gp][gh] = blk_base(dec[gp].blk) + dec[gp].hw + 18'(gh);
        assign rd[gp][16*gh +: 16] =
          (3'(gh) >= nhw[gp])               ? 16'h0000 :
          (dec[gp].kind == memmap_pkg::K_ROM) ? ROM_FILL :
          (dec[gp].kind == memmap_pkg::K_SRAM && idx[gp][gh] < 18'(NHW))
                                            ? sram[idx[gp][gh]] : 16'h0000;
      end
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    for (int p = 0; p < 3; p++) begin
      st_nxt.rsp[p] = '0;
      st_nxt.per[p] = '0;
      if (reqs[p].valid) begin
        st_nxt.rsp[p].ack = 1'b1;
        st_nxt.rsp[p].err = (dec[p].kind == memmap_pkg::K_NONE) ||
                            (dec[p].kind == memmap_pkg::K_ROM && reqs[p].we);
        if (dec[p].kind == memmap_pkg::K_PERIPH) begin
          st_nxt.rsp[p].periph = 1'b1;
          st_nxt.per[p].valid = 1'b1;
          st_nxt.per[p].we = reqs[p].we;
          st_nxt.per[p].addr = reqs[p].addr[17:0];
          st_nxt.per[p].wdata = reqs[p].wdata[31:0];
        end else if (!reqs[p].we) begin
          st_nxt.rsp[p].rdata = rd[p];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Same-halfword collisions: data bus beats program bus beats I/O processor
  always_ff @(posedge clk) begin
    for (int p = 2; p >= 0; p--) begin
      if (reqs[p].valid && reqs[p].we && dec[p].kind == memmap_pkg::K_SRAM) begin
        for (int h = 0; h < 4; h++) begin
          if (3'(h) < nhw[p] && idx[p][h] < 18'(NHW)) begin
            sram[idx[p][h]] <= reqs[p].wdata[16*h +: 16];
          end
        end
      end
    end
  end

  assign data_memory_bus_rsp    = st_r.rsp[0];
  assign program_memory_bus_rsp = st_r.rsp[1];
  assign io_processor_rsp       = st_r.rsp[2];
  assign data_memory_bus_per    = st_r.per[0];
  assign program_memory_bus_per = st_r.per[1];
  assign io_processor_per       = st_r.per[2];

endmodule : memmap_core

//--- memmap_checker.sv
// Purpose: Port-level checks of the memory decoder
// Assumes: Requests are one-cycle strobes
// Notes:   Bound into every memmap_core
`timescale 1ns/100ps
module memmap_checker (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // Three ports
  input wire memmap_pkg::req_t    data_memory_bus_req,
  input wire memmap_pkg::rsp_t    data_memory_bus_rsp,
  input wire memmap_pkg::periph_t data_memory_bus_per,
  input wire memmap_pkg::req_t    program_memory_bus_req,
  input wire memmap_pkg::rsp_t    program_memory_bus_rsp,
  input wire memmap_pkg::periph_t program_memory_bus_per,
  input wire memmap_pkg::req_t    io_processor_req,
  input wire memmap_pkg::rsp_t    io_processor_rsp,
  input wire memmap_pkg::periph_t io_processor_per
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  memmap_pkg::req_t dq;
  memmap_pkg::rsp_t ds;
  assign dq = data_memory_bus_req;
  assign ds = data_memory_bus_rsp;
  a_dm_ack_next: assert property (dq.valid |=> ds.ack) else $error("dm ack late");
  a_pm_ack_next: assert property (program_memory_bus_req.valid |=> program_memory_bus_rsp.ack)
    else $error("pm ack late");
  a_io_ack_next: assert property (io_processor_req.valid |=> io_processor_rsp.ack)
    else $error("io ack late");
  a_dm_ack_quiet: assert property (!dq.valid |=> !ds.ack && !data_memory_bus_per.valid)
    else $error("spurious answer");
  a_periph_route: assert property (dq.valid && dq.addr <= 32'h0003FFFF |=> ds.periph && !ds.err
    && data_memory_bus_per.valid && {14'h0000, data_memory_bus_per.addr} == $past(dq.addr))
    else $error("periph not routed");
  a_short_gap: assert property (dq.valid && dq.addr inside {[32'h00188000:32'h001BFFFF]}
    |=> ds.err && ds.rdata == 64'h0) else $error("gap mapped");
  a_rom_write: assert property (dq.valid && dq.we && dq.addr inside {[32'h00080000:32'h0008FFFF]}
    |=> ds.err) else $error("rom write taken");
  a_sram_ok: assert property (dq.valid && !dq.ext48 && dq.addr inside {[32'h00098000:32'h0009FFFF]}
    |=> !ds.err && !ds.periph) else $error("sram refused");
  c_all_three: cover property (dq.valid && program_memory_bus_req.valid && io_processor_req.valid);
  c_periph: cover property (dq.valid && dq.addr <= 32'h0003FFFF);
  c_gap: cover property (dq.valid && dq.addr inside {[32'h00188000:32'h001BFFFF]});
endmodule : memmap_checker

bind memmap_core memmap_checker u_chk (.*);

//--- memmap_requester.sv
// Purpose: Requester stand-in for a core bus or the I/O processor
// Assumes: The bench stages one request per cycle just after the edge
// Notes:   Nothing is presented while reset is low
`timescale 1ns/100ps
module memmap_requester (
  // Reset
  input  wire logic             rst_n,
  // Staged and presented request
  input  wire memmap_pkg::req_t stage,
  output      memmap_pkg::req_t req
);
  assign req = rst_n ? stage : '0;
endmodule : memmap_requester

//--- tb_memmap_core.sv
// Purpose: Random and directed traffic on all three memory ports
// Assumes: Answers appear just after the taking edge
// Notes:   A halfword model predicts every read
`timescale 1ns/100ps
module tb_memmap_core;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  memmap_pkg::req_t    stg [3];
  memmap_pkg::req_t    rq [3];
  memmap_pkg::rsp_t    rs [3];
  memmap_pkg::periph_t pr [3];
  logic [15:0]         mem [int];
  logic [15:0]         lf = 16'hC8D9;
  int                  kd [3];
  int                  ix [3];
  int                  k;
  int                  err_count = 0;
  int                  cmp_count = 0;
  always #25 clk = ~clk;
  for (genvar g = 0; g < 3; g++) begin : g_req
    memmap_requester u_req (.rst_n(rst_n), .stage(stg[g]), .req(rq[g]));
  end
  memmap_core u_dut (.clk(clk), .rst_n(rst_n),
    .data_memory_bus_req(rq[0]), .data_memory_bus_rsp(rs[0]), .data_memory_bus_per(pr[0]),
    .program_memory_bus_req(rq[1]), .program_memory_bus_rsp(rs[1]),
    .program_memory_bus_per(pr[1]),
    .io_processor_req(rq[2]), .io_processor_rsp(rs[2]), .io_processor_per(pr[2]));
  function automatic int rnd(int m);
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return int'(lf) % m;
  endfunction : rnd
  function automatic logic [31:0] base(int k, int b);
    case (k)
      // Blocks 2 and 3 have no reserved gap below their SRAM
      0: return b < 2 ? 32'h0004C000 + 32'(b) * 32'h00010000
                      : 32'h00060000 + 32'(b - 2) * 32'h00010000;
      1: return b < 2 ? 32'h00090000 + 32'(b) * 32'h00020000
                      : 32'h000C0000 + 32'(b - 2) * 32'h00020000;
      2: return b < 2 ? 32'h00098000 + 32'(b) * 32'h00020000
                      : 32'h000C0000 + 32'(b - 2) * 32'h00020000;
      3: return b < 2 ? 32'h00130000 + 32'(b) * 32'h00040000
                      : 32'h00180000 + 32'(b - 2) * 32'h00040000;
      4: return 32'h00000000;
      5: return 32'h00188000;
      6: return 32'h00080000;
      default: return 32'h00200000;
    endcase
  endfunction : base
  task automatic pick(int p, int k, int b, int n, logic w);
    stg[p] = '{valid: 1'b1, we: w, ext48: k == 1, addr: base(k, b) + 32'(n),
      wdata: {16'(rnd(65536)), 16'(rnd(65536)), 16'(rnd(65536)), 16'(rnd(65536))}};
    kd[p] = k;
    ix[p] = (b < 2 ? b * 65536 : 131072 + (b - 2) * 32768) + n * (4 - k);
  endtask : pick
  task automatic chk(logic [127:0] s, logic [127:0] x);
    cmp_count++;
    if (s !== x) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic step();
    memmap_pkg::rsp_t    e [3];
    memmap_pkg::periph_t f [3];
    for (int p = 0; p < 3; p++) begin
      e[p] = '0;
      f[p] = '0;
      if (stg[p].valid && kd[p] == 4) begin
        f[p].valid = 1'b1;
        f[p].we = stg[p].we;
        f[p].addr = stg[p].addr[17:0];
        f[p].wdata = stg[p].wdata[31:0];
      end
      e[p].ack = stg[p].valid;
      e[p].periph = stg[p].valid && kd[p] == 4;
      e[p].err = stg[p].valid && (kd[p] == 5 || kd[p] == 7 || (kd[p] == 6 && stg[p].we));
      for (int j = 0; j < 4 - kd[p]; j++)
        if (stg[p].valid && !stg[p].we) e[p].rdata[16*j +: 16] = mem[ix[p] + j];
    end
    @(posedge clk);
    #1;
    for (int p = 2; p >= 0; p--) begin
      chk(128'(rs[p]), 128'(e[p]));
      chk(128'(pr[p]), 128'(f[p]));
      for (int j = 0; j < 4 - kd[p]; j++)
        if (stg[p].valid && stg[p].we) mem[ix[p] + j] = stg[p].wdata[16*j +: 16];
    end
  endtask : step
  task automatic final_report();
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    for (int p = 0; p < 3; p++) stg[p] = '0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    for (int n = 0; n < 64; n++) begin
      pick(0, 0, 0, n, 1'b1);
      pick(1, 0, 1, n, 1'b1);
      pick(2, 4, 0, n, 1'b1);
      step();
    end
    pick(0, 5, 0, 32'h00037FFF, 1'b0);
    pick(1, 7, 0, 0, 1'b1);
    pick(2, 6, 0, 0, 1'b1);
    step();
    for (int t = 0; t < 3000; t++) begin
      for (int p = 0; p < 3; p++) begin
        k = rnd(8);
        if (rnd(5) == 0) stg[p] = '0;
        else pick(p, k, rnd(4), rnd(k == 0 ? 64 : k == 1 ? 85 : k == 2 ? 128 : 256), rnd(2) == 1);
      end
      step();
    end
    final_report();
  end
  initial begin
    #250000;
    err_count++;
    final_report();
  end
endmodule : tb_memmap_core
